// File: rtl/sbcspi_port.sv
`timescale 1ns/1ps
module sbcspi_port
	import sbcspi_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_chip_select_low_n,
	input  wire logic        i_sck,
	input  wire logic        i_mosi,
	input  wire logic        i_regulator_overtemp_warn,
	input  wire logic        i_battery_divider_visible,
	input  wire logic        i_bus_driver_overtemp,
	input  wire logic        i_source_overtemp,
	input  wire logic        i_ignition_pin_state,
	input  wire logic [2:0]  i_monitor_addr,
	input  wire logic        i_watchdog_state,
	input  wire logic        i_supply_undervolt,
	input  wire logic        i_irq_event,
	input  wire logic [1:0]  i_irq_cause,
	input  wire logic [7:0]  i_switch_comp_state,
	output logic             o_miso,
	output logic             o_miso_oe,
	output logic      [15:0] o_config,
	output logic             o_config_load,
	output logic      [1:0]  o_irq_cause
);

	logic [2:0]          pins_f;
	wire                 cs_n_f;
	wire                 sck_f;
	wire                 mosi_f;
	logic                cs_n_d_r;
	logic                sck_d_r;
	wire                 cs_fall;
	wire                 cs_rise;
	wire                 sck_rise;
	wire                 sck_fall;

	sbcspi_state_t       state_r;
	sbcspi_state_t       state_nxt;
	logic [15:0]         status_w;
	logic [15:0]         shift_r;
	logic [15:0]         shift_nxt;
	logic [15:0]         rx_r;
	logic [15:0]         rx_nxt;
	logic                sample_r;
	logic                sample_nxt;
	logic                seen_rise_r;
	logic                seen_rise_nxt;
	logic [5:0]          count_r;
	logic [5:0]          count_nxt;
	logic [15:0]         config_r;
	logic [15:0]         config_nxt;
	logic                load_r;
	logic                load_nxt;
	logic [1:0]          irq_r;
	logic [1:0]          irq_nxt;
	logic                miso_r;
	logic                miso_nxt;
	logic                oe_r;
	logic                oe_nxt;
	wire                 in_frame;
	wire                 do_shift;
	wire                 commit;
	wire                 irq_clear;

	sbcspi_pin_filter #(
		.WIDTH     (SBCSPI_PINS),
		.RESET_VAL (SBCSPI_PIN_RESET)
	) u_filter (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_pins    ({i_chip_select_low_n, i_sck, i_mosi}),
		.o_pins    (pins_f)
	);

	assign cs_n_f = pins_f[2];
	assign sck_f  = pins_f[1];
	assign mosi_f = pins_f[0];

	assign cs_fall  = cs_n_d_r & ~cs_n_f;
	assign cs_rise  = ~cs_n_d_r & cs_n_f;
	assign sck_rise = ~sck_d_r & sck_f;
	assign sck_fall = sck_d_r & ~sck_f;

	// Clock edges count only inside a frame opened by a select edge
	assign in_frame = (state_r == SBCSPI_ST_FRAME) & ~cs_n_f;

	// A falling edge before any rising edge is the mode 1/1 lead-in
	assign do_shift = in_frame & sck_fall & seen_rise_r;

	// Load only on an exact single-word frame
	assign commit = (state_r == SBCSPI_ST_FRAME) & cs_rise
	              & (count_r == SBCSPI_CNT_WORD);

	// Field is read once the word's last bit has been taken by the master
	assign irq_clear = in_frame & sck_rise & (count_r == SBCSPI_CNT_LAST);

	// Previous command's divider enable picks the upper field
	sbcspi_status_word u_status (
		.i_divider_output_enable   (config_r[SBCSPI_CFG_DIVEN]),
		.i_regulator_overtemp_warn (i_regulator_overtemp_warn),
		.i_battery_divider_visible (i_battery_divider_visible),
		.i_bus_driver_overtemp     (i_bus_driver_overtemp),
		.i_source_overtemp         (i_source_overtemp),
		.i_ignition_pin_state      (i_ignition_pin_state),
		.i_monitor_addr            (i_monitor_addr),
		.i_watchdog_state          (i_watchdog_state),
		.i_supply_undervolt        (i_supply_undervolt),
		.i_irq_cause               (irq_r),
		.i_switch_comp_state       (i_switch_comp_state),
		.o_word                    (status_w)
	);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SBCSPI_ST_IDLE:
			begin
				if (cs_fall)
					state_nxt = SBCSPI_ST_FRAME;
			end
			SBCSPI_ST_FRAME:
			begin
				if (cs_rise)
					state_nxt = SBCSPI_ST_IDLE;
			end
			default:
				state_nxt = SBCSPI_ST_IDLE;
		endcase
	end

	// Status enters first, then received bits follow it out
	assign shift_nxt = cs_fall ? status_w
	                 : do_shift ? {shift_r[14:0], sample_r}
	                 : shift_r;

	assign rx_nxt = (in_frame & sck_rise) ? {rx_r[14:0], mosi_f}
	              : rx_r;

	assign sample_nxt = (in_frame & sck_rise) ? mosi_f : sample_r;

	assign seen_rise_nxt = cs_fall ? 1'b0
	                     : (in_frame & sck_rise) ? 1'b1
	                     : seen_rise_r;

	assign count_nxt = cs_fall ? 6'h00
	                 : (in_frame & sck_rise & (count_r != SBCSPI_CNT_MAX))
	                   ? count_r + 6'h01
	                 : count_r;

	assign config_nxt = commit ? rx_r : config_r;
	assign load_nxt   = commit;

	// A new cause wins over a readout clear in the same cycle
	assign irq_nxt = i_irq_event ? i_irq_cause
	               : irq_clear ? SBCSPI_IRQ_POWERUP
	               : irq_r;

	// Output is driven only while a frame is open
	assign oe_nxt   = (state_nxt == SBCSPI_ST_FRAME) & ~cs_n_f;
	assign miso_nxt = oe_nxt & shift_nxt[15];

	// Reset level matches the idle select pin, so no false edge
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cs_n_d_r <= 1'b1;
		end
		else
		begin
			cs_n_d_r <= cs_n_f;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sck_d_r <= 1'b0;
		end
		else
		begin
			sck_d_r <= sck_f;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= SBCSPI_ST_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			shift_r <= SBCSPI_SR_RESET;
		end
		else
		begin
			shift_r <= shift_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rx_r <= SBCSPI_CFG_RESET;
		end
		else
		begin
			rx_r <= rx_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sample_r <= 1'b0;
		end
		else
		begin
			sample_r <= sample_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			seen_rise_r <= 1'b0;
		end
		else
		begin
			seen_rise_r <= seen_rise_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			count_r <= 6'h00;
		end
		else
		begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			config_r <= SBCSPI_CFG_RESET;
		end
		else
		begin
			config_r <= config_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			load_r <= 1'b0;
		end
		else
		begin
			load_r <= load_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			irq_r <= SBCSPI_IRQ_POWERUP;
		end
		else
		begin
			irq_r <= irq_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			miso_r <= 1'b0;
		end
		else
		begin
			miso_r <= miso_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			oe_r <= 1'b0;
		end
		else
		begin
			oe_r <= oe_nxt;
		end
	end

	assign o_miso        = miso_r;
	assign o_miso_oe     = oe_r;
	assign o_config      = config_r;
	assign o_config_load = load_r;
	assign o_irq_cause   = irq_r;

endmodule

// File: rtl/sbcspi_pkg.sv
package sbcspi_pkg;

	localparam int          SBCSPI_WORD_BITS  = 16;
	localparam int          SBCSPI_CNT_W      = 6;
	localparam logic [5:0]  SBCSPI_CNT_MAX    = 6'h3F;
	localparam logic [5:0]  SBCSPI_CNT_WORD   = 6'h10;
	localparam logic [5:0]  SBCSPI_CNT_LAST   = 6'h0F;

	localparam logic [15:0] SBCSPI_CFG_RESET  = 16'h0000;
	localparam logic [15:0] SBCSPI_SR_RESET   = 16'h0000;
	localparam int          SBCSPI_CFG_DIVEN  = 10;

	// Status word field positions
	localparam int          SBCSPI_ST_B15     = 15;
	localparam int          SBCSPI_ST_B14     = 14;
	localparam int          SBCSPI_ST_B13     = 13;
	localparam int          SBCSPI_ST_B12     = 12;
	localparam int          SBCSPI_ST_WDOG    = 11;
	localparam int          SBCSPI_ST_UVOLT   = 10;
	localparam int          SBCSPI_ST_IRQ_HI  = 9;
	localparam int          SBCSPI_ST_IRQ_LO  = 8;
	localparam int          SBCSPI_ST_SW_HI   = 7;
	localparam int          SBCSPI_ST_SW_LO   = 0;

	typedef enum logic [1:0] {
		SBCSPI_IRQ_POWERUP = 2'h0,
		SBCSPI_IRQ_SWITCH  = 2'h1,
		SBCSPI_IRQ_IGNIT   = 2'h2,
		SBCSPI_IRQ_BUSWAKE = 2'h3
	} sbcspi_irq_t;

	// Pin filter order {select_n, sck, mosi}
	localparam int          SBCSPI_PINS       = 3;
	localparam logic [2:0]  SBCSPI_PIN_RESET  = 3'h4;

	typedef enum logic {
		SBCSPI_ST_IDLE,
		SBCSPI_ST_FRAME
	} sbcspi_state_t;

endpackage

// File: rtl/sbcspi_pin_filter.sv
`timescale 1ns/1ps
module sbcspi_pin_filter
	import sbcspi_pkg::*;
#(
	parameter int         WIDTH     = 3,
	parameter logic [2:0] RESET_VAL = 3'h0
)
(
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_pins,
	output logic      [WIDTH-1:0] o_pins
);

	logic [WIDTH-1:0] ff1_r;
	logic [WIDTH-1:0] ff2_r;
	logic [WIDTH-1:0] ff3_r;
	logic [WIDTH-1:0] filt_r;
	logic [WIDTH-1:0] filt_nxt;

	// Bit follows only when the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			assign filt_nxt[g] = (ff2_r[g] == ff3_r[g]) ? ff3_r[g] : filt_r[g];
		end
	endgenerate

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ff1_r  <= RESET_VAL[WIDTH-1:0];
			ff2_r  <= RESET_VAL[WIDTH-1:0];
			ff3_r  <= RESET_VAL[WIDTH-1:0];
			filt_r <= RESET_VAL[WIDTH-1:0];
		end
		else
		begin
			ff1_r  <= i_pins;
			ff2_r  <= ff1_r;
			ff3_r  <= ff2_r;
			filt_r <= filt_nxt;
		end
	end

	assign o_pins = filt_r;

endmodule

// File: rtl/sbcspi_status_word.sv
`timescale 1ns/1ps
module sbcspi_status_word
	import sbcspi_pkg::*;
(
	input  wire logic        i_divider_output_enable,
	input  wire logic        i_regulator_overtemp_warn,
	input  wire logic        i_battery_divider_visible,
	input  wire logic        i_bus_driver_overtemp,
	input  wire logic        i_source_overtemp,
	input  wire logic        i_ignition_pin_state,
	input  wire logic [2:0]  i_monitor_addr,
	input  wire logic        i_watchdog_state,
	input  wire logic        i_supply_undervolt,
	input  wire logic [1:0]  i_irq_cause,
	input  wire logic [7:0]  i_switch_comp_state,
	output logic      [15:0] o_word
);

	wire       b15_w;
	wire [2:0] b14_12_w;

	assign b15_w = i_divider_output_enable ? i_battery_divider_visible
	                                       : i_regulator_overtemp_warn;
	assign b14_12_w = i_divider_output_enable ? i_monitor_addr
	                : {i_bus_driver_overtemp,
	                   i_source_overtemp,
	                   i_ignition_pin_state};

	always_comb
	begin
		o_word = SBCSPI_SR_RESET;
		o_word[SBCSPI_ST_B15] = b15_w;
		o_word[SBCSPI_ST_B14:SBCSPI_ST_B12] = b14_12_w;
		o_word[SBCSPI_ST_WDOG] = i_watchdog_state;
		o_word[SBCSPI_ST_UVOLT] = i_supply_undervolt;
		o_word[SBCSPI_ST_IRQ_HI:SBCSPI_ST_IRQ_LO] = i_irq_cause;
		o_word[SBCSPI_ST_SW_HI:SBCSPI_ST_SW_LO] = i_switch_comp_state;
	end

endmodule

// File: bench/sbcspi_port_assertions.sv
`timescale 1ns/1ps
module sbcspi_port_assertions
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_chip_select_low_n,
	input  wire logic        i_regulator_overtemp_warn,
	input  wire logic        i_battery_divider_visible,
	input  wire logic        i_irq_event,
	input  wire logic [1:0]  i_irq_cause,
	input  wire logic        o_miso,
	input  wire logic        o_miso_oe,
	input  wire logic [15:0] o_config,
	input  wire logic        o_config_load,
	input  wire logic [1:0]  o_irq_cause
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_sel_quiet;
		i_chip_select_low_n [*8];
	endsequence
	a_quiet_no_drive: assert property (s_sel_quiet |-> !o_miso_oe)
		else $error("data output enabled while deselected");
	a_miso_released: assert property (!o_miso_oe |-> !o_miso)
		else $error("data output not released");
	a_load_single: assert property (o_config_load |=> !o_config_load)
		else $error("config load longer than one cycle");
	a_config_on_load: assert property ($changed(o_config) |-> o_config_load)
		else $error("config changed without load");
	a_load_deselected: assert property (o_config_load |->
		i_chip_select_low_n && $past(i_chip_select_low_n, 3) && !o_miso_oe)
		else $error("config load while selected");
	a_irq_latch: assert property (i_irq_event |=>
		o_irq_cause == $past(i_irq_cause))
		else $error("cause not latched");
	a_cause_clear: assert property ($changed(o_irq_cause) &&
		!$past(i_irq_event) |-> o_irq_cause == 2'h0 && $past(o_miso_oe))
		else $error("cause changed outside readout");
	a_first_bit: assert property ($rose(o_miso_oe) |-> o_miso ==
		(o_config[10] ? $past(i_battery_divider_visible)
			: $past(i_regulator_overtemp_warn)))
		else $error("first status bit wrong");
	a_drop_deselect: assert property ($fell(o_miso_oe) |->
		i_chip_select_low_n)
		else $error("output dropped while selected");
endmodule
bind sbcspi_port sbcspi_port_assertions i_sbcspi_port_assertions
(
	.i_ref_clk,
	.i_rst,
	.i_chip_select_low_n,
	.i_regulator_overtemp_warn,
	.i_battery_divider_visible,
	.i_irq_event,
	.i_irq_cause,
	.o_miso,
	.o_miso_oe,
	.o_config,
	.o_config_load,
	.o_irq_cause
);

// File: bench/sbcspi_master_model.sv
`timescale 1ns/1ps
module sbcspi_master_model
(
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_mosi
);
	initial
	begin
		o_cs_n = 1'h1;
		o_sck = 1'h0;
		o_mosi = 1'h0;
	end
	// Samples just before the shifting edge
	task automatic xfer(input int n, input logic [31:0] tx,
		input logic pol, output logic [31:0] rx);
		rx = 32'h0;
		o_sck = pol;
		#200 o_cs_n = 1'h0;
		#200;
		for (int i = 0; i < n; i++)
		begin
			if (pol)
				o_sck = 1'h0;
			o_mosi = tx[n-1-i];
			#80 o_sck = 1'h1;
			// Released line reads as the inverse of the current i_miso level, which is low, so as 1
			#80 rx = {rx[30:0], i_miso_oe ? i_miso : ~i_miso};
			if (!pol)
				o_sck = 1'h0;
		end
		#200 o_cs_n = 1'h1;
		o_mosi = ~o_mosi;
		#400;
	endtask
	task automatic noise;
		repeat (8)
		begin
			#80 o_sck = ~o_sck;
			o_mosi = ~o_mosi;
		end
	endtask
endmodule

// File: bench/sbc_spi_status_daisy_chain_tb_top.sv
`timescale 1ns/1ps
module sbc_spi_status_daisy_chain_tb_top;
	logic clk, rst, cs_n, sck, mosi, otw, bdv, bdo, so, ign, wd, uv;
	logic irq_ev, miso, oe, cfg_ld, dv;
	logic [2:0]  addr;
	logic [1:0]  irq_c, cause;
	logic [7:0]  sw;
	logic [15:0] cfg, cmd;
	logic [31:0] rx;
	int          n_mismatch, n_tests, n_load;
	sbcspi_port i_sbcspi_port (.i_ref_clk(clk), .i_rst(rst),
		.i_chip_select_low_n(cs_n), .i_sck(sck), .i_mosi(mosi),
		.i_regulator_overtemp_warn(otw), .i_battery_divider_visible(bdv),
		.i_bus_driver_overtemp(bdo), .i_source_overtemp(so),
		.i_ignition_pin_state(ign), .i_monitor_addr(addr),
		.i_watchdog_state(wd), .i_supply_undervolt(uv), .i_irq_event(irq_ev),
		.i_irq_cause(irq_c), .i_switch_comp_state(sw), .o_miso(miso),
		.o_miso_oe(oe), .o_config(cfg), .o_config_load(cfg_ld),
		.o_irq_cause(cause));
	sbcspi_master_model i_sbcspi_master_model (.i_miso(miso),
		.i_miso_oe(oe), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));
	function automatic logic [15:0] exp_st(input logic d, input logic [1:0] c);
		exp_st = d ? {bdv, addr, wd, uv, c, sw} : {otw, bdo, so, ign, wd, uv, c, sw};
	endfunction
	task automatic chk_word(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask
	// Load pulse stands one cycle, seen once at the falling edge
	always @(negedge clk)
		if (cfg_ld)
			n_load <= n_load + 1;
	task automatic pulse_irq(input logic [1:0] c);
		@(negedge clk);
		irq_c = c;
		irq_ev = 1'h1;
		@(negedge clk);
		irq_ev = 1'h0;
	endtask
	task results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#100000 n_mismatch++;
		results;
	end
	initial
	begin
		{rst, otw, bdv, bdo, so, ign, wd, uv, irq_ev, dv} = 10'h200;
		{addr, irq_c, sw, n_mismatch, n_tests} = 0;
		repeat (3) @(negedge clk);
		rst = 1'h0;
		repeat (8) @(negedge clk);
		chk_bit("oe_idle", 1'h0, oe);
		chk_word("config_rst", 32'h0, {16'h0, cfg});
		for (int c = 0; c < 4; c++)
		begin
			{otw, bdo, so, ign} = {c[0], ~c[0], c[1], ~c[1]};
			{bdv, wd, uv, addr, sw} = {~c[0], c[0], c[1], 3'(c + 3), 8'h81 << c};
			pulse_irq(2'(c));
			cmd = c[0] ? 16'h3A00 : 16'h0455;
			i_sbcspi_master_model.xfer(16, {16'h0, cmd}, c[1], rx);
			chk_word("status", {16'h0, exp_st(dv, 2'(c))}, rx);
			chk_word("config", {16'h0, cmd}, {16'h0, cfg});
			chk_word("cause_clr", 32'h0, {30'h0, cause});
			dv = cmd[10];
		end
		pulse_irq(2'h2);
		i_sbcspi_master_model.xfer(32, 32'hC35A1234, 1'h1, rx);
		chk_word("chain", {exp_st(dv, 2'h2), 16'hC35A}, rx);
		chk_word("chain_cfg", {16'h0, cmd}, {16'h0, cfg});
		i_sbcspi_master_model.noise;
		repeat (8) @(negedge clk);
		chk_word("noise_cfg", {16'h0, cmd}, {16'h0, cfg});
		chk_bit("noise_oe", 1'h0, oe);
		// Cut frame: no load, cause kept until a full readout
		pulse_irq(2'h3);
		i_sbcspi_master_model.xfer(8, 32'hAB, 1'h0, rx);
		chk_word("short_st", {16'h0, exp_st(dv, 2'h3) >> 8}, rx);
		chk_word("short_cfg", {16'h0, cmd}, {16'h0, cfg});
		chk_word("cause_keep", 32'h3, {30'h0, cause});
		chk_word("loads", 32'h4, n_load);
		results;
	end
endmodule
